// ---- ipv4bc_top.sv ----
module ipv4bc_top
	import ipv4bc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [4:0] reg_phy_addr_i,
	input wire logic [11:0] reg_page_i,
	input wire logic [5:0] reg_num_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic pkt_valid_i,
	input wire logic [10:0] tcp_port_hit_i,
	input wire logic udp_port_filter_zero_hit_i,
	input wire logic eap_udp_hit_i,
	input wire logic dns_hit_i,
	input wire logic [11:0] flex_port_hit_i,
	input wire logic range_port_filter_hit_i,
	input wire logic icmp_hit_i,
	input wire logic arp_hit_i,
	input wire logic rmcp_hit_i,
	input wire logic mgmt_ipv4_match_i,
	input wire logic host_ipv4_match_i,
	output logic pass_valid_o,
	output logic [31:0] mgmt_pass_o,
	output logic [16:0] host_pass_o,
	output logic [31:0] mgmt_bind_o,
	output logic [16:0] host_bind_o
);

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic reg_sel(input logic [4:0] addr, input logic [11:0] page,
			input logic [5:0] num, input logic [5:0] want);
		reg_sel = (addr == IPV4BC_PHY_ADDR) && (page == IPV4BC_PAGE) && (num == want);
	endfunction

	// Only writable bits take new data; reserved bits stay at zero
	function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [15:0] data,
			input logic [15:0] mask);
		wr_merge = (old & ~mask) | (data & mask);
	endfunction

	// ==========================================================
	// Binding registers
	// ==========================================================
	logic [31:0] mgmt_bind_q;
	logic [31:0] host_bind_q;
	logic sel_mgmt_lo;
	logic sel_mgmt_hi;
	logic sel_host_lo;
	logic sel_host_hi;

	assign sel_mgmt_lo = reg_sel(reg_phy_addr_i, reg_page_i, reg_num_i, IPV4BC_REG_MGMT_LO);
	assign sel_mgmt_hi = reg_sel(reg_phy_addr_i, reg_page_i, reg_num_i, IPV4BC_REG_MGMT_HI);
	assign sel_host_lo = reg_sel(reg_phy_addr_i, reg_page_i, reg_num_i, IPV4BC_REG_HOST_LO);
	assign sel_host_hi = reg_sel(reg_phy_addr_i, reg_page_i, reg_num_i, IPV4BC_REG_HOST_HI);

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mgmt_bind_q <= IPV4BC_MGMT_RESET;
		end else if (reg_wr_i) begin
			if (sel_mgmt_lo) begin
				mgmt_bind_q[15:0] <= wr_merge(mgmt_bind_q[15:0], reg_wdata_i, IPV4BC_MGMT_WMASK[15:0]);
			end
			if (sel_mgmt_hi) begin
				mgmt_bind_q[31:16] <= wr_merge(mgmt_bind_q[31:16], reg_wdata_i, IPV4BC_MGMT_WMASK[31:16]);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			host_bind_q <= IPV4BC_HOST_RESET;
		end else if (reg_wr_i) begin
			if (sel_host_lo) begin
				host_bind_q[15:0] <= wr_merge(host_bind_q[15:0], reg_wdata_i, IPV4BC_HOST_WMASK[15:0]);
			end
			if (sel_host_hi) begin
				host_bind_q[31:16] <= wr_merge(host_bind_q[31:16], reg_wdata_i, IPV4BC_HOST_WMASK[31:16]);
			end
		end
	end

	// ==========================================================
	// Read port
	// ==========================================================
	// Every read is answered one cycle later; registers outside this bank read zero
	logic [15:0] rdata_d;

	always_comb begin
		rdata_d = 16'h0000;
		if (sel_mgmt_lo) begin
			rdata_d = mgmt_bind_q[15:0];
		end else if (sel_mgmt_hi) begin
			rdata_d = mgmt_bind_q[31:16];
		end else if (sel_host_lo) begin
			rdata_d = host_bind_q[15:0];
		end else if (sel_host_hi) begin
			rdata_d = host_bind_q[31:16];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
		end
	end

	// Data holds between reads so a slow poller can still pick it up
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_d;
		end
	end

	// ==========================================================
	// Filter hit vector in register bit layout
	// ==========================================================
	logic [31:0] hit_vec;
	logic [31:0] mgmt_match_vec;
	logic [16:0] host_match_vec;
	logic [31:0] mgmt_pass;
	logic [16:0] host_pass;

	always_comb begin
		hit_vec = 32'h0000_0000;
		hit_vec[IPV4BC_TCP_LSB +: IPV4BC_TCP_NUM] = tcp_port_hit_i;
		hit_vec[IPV4BC_UDP0_BIT] = udp_port_filter_zero_hit_i;
		hit_vec[IPV4BC_EAP_BIT] = eap_udp_hit_i;
		hit_vec[IPV4BC_DNS_BIT] = dns_hit_i;
		hit_vec[IPV4BC_FLEX_LSB +: IPV4BC_FLEX_NUM] = flex_port_hit_i;
		hit_vec[IPV4BC_RANGE_BIT] = range_port_filter_hit_i;
		hit_vec[IPV4BC_ICMP_BIT] = icmp_hit_i;
		hit_vec[IPV4BC_ARP_BIT] = arp_hit_i;
		hit_vec[IPV4BC_RMCP_BIT] = rmcp_hit_i;
	end

	// RMCP is tied to the host address even in the management register
	always_comb begin
		mgmt_match_vec = {32{mgmt_ipv4_match_i}};
		mgmt_match_vec[IPV4BC_RMCP_BIT] = host_ipv4_match_i;
		host_match_vec = {IPV4BC_HOST_W{host_ipv4_match_i}};
	end

	ipv4bc_qualify #(
		.W(32)
	) u_mgmt_qual (
		.hit_i(hit_vec),
		.bind_i(mgmt_bind_q),
		.match_i(mgmt_match_vec),
		.pass_o(mgmt_pass)
	);

	ipv4bc_qualify #(
		.W(IPV4BC_HOST_W)
	) u_host_qual (
		.hit_i(hit_vec[IPV4BC_HOST_W-1:0]),
		.bind_i(host_bind_q[IPV4BC_HOST_W-1:0]),
		.match_i(host_match_vec),
		.pass_o(host_pass)
	);

	// ==========================================================
	// Registered verdicts
	// ==========================================================
	// One cycle of latency buys clean flop outputs toward the routing logic
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pass_valid_o <= 1'b0;
		end else begin
			pass_valid_o <= pkt_valid_i;
		end
	end

	// Verdicts hold between packets; consumers qualify them with pass_valid_o
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mgmt_pass_o <= 32'h0000_0000;
		end else if (pkt_valid_i) begin
			mgmt_pass_o <= mgmt_pass;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			host_pass_o <= 17'h0_0000;
		end else if (pkt_valid_i) begin
			host_pass_o <= host_pass;
		end
	end

	// Register copies lag by one cycle so they line up with the verdict they explain
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mgmt_bind_o <= 32'h0000_0000;
		end else begin
			mgmt_bind_o <= mgmt_bind_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			host_bind_o <= 17'h0_0000;
		end else begin
			host_bind_o <= host_bind_q[IPV4BC_HOST_W-1:0];
		end
	end

endmodule

// ---- ipv4bc_pkg.sv ----
package ipv4bc_pkg;

	// ==========================================================
	// Register access decode
	// ==========================================================
	localparam logic [4:0] IPV4BC_PHY_ADDR = 5'h01;
	localparam logic [11:0] IPV4BC_PAGE = 12'h321;
	localparam logic [5:0] IPV4BC_REG_MGMT_LO = 6'h28;
	localparam logic [5:0] IPV4BC_REG_MGMT_HI = 6'h29;
	localparam logic [5:0] IPV4BC_REG_HOST_LO = 6'h2A;
	localparam logic [5:0] IPV4BC_REG_HOST_HI = 6'h2B;

	// ==========================================================
	// Field layout of both binding registers
	// ==========================================================
	localparam int IPV4BC_TCP_LSB = 0;
	localparam int IPV4BC_TCP_NUM = 11;
	localparam int IPV4BC_RSVD_A = 11;
	localparam int IPV4BC_UDP0_BIT = 12;
	localparam int IPV4BC_RSVD_B = 13;
	localparam int IPV4BC_EAP_BIT = 14;
	localparam int IPV4BC_DNS_BIT = 15;
	localparam int IPV4BC_FLEX_LSB = 16;
	localparam int IPV4BC_FLEX_NUM = 12;
	localparam int IPV4BC_RANGE_BIT = 28;
	localparam int IPV4BC_ICMP_BIT = 29;
	localparam int IPV4BC_ARP_BIT = 30;
	localparam int IPV4BC_RMCP_BIT = 31;
	localparam int IPV4BC_HOST_W = 17;

	// ==========================================================
	// Writable masks and reset values
	// ==========================================================
	localparam logic [31:0] IPV4BC_MGMT_WMASK = 32'hFFFF_D7FF;
	localparam logic [31:0] IPV4BC_HOST_WMASK = 32'h0001_D7FF;
	localparam logic [31:0] IPV4BC_MGMT_RESET = 32'h0000_0000;
	localparam logic [31:0] IPV4BC_HOST_RESET = 32'h0000_0000;

endpackage

// ---- ipv4bc_qualify.sv ----
module ipv4bc_qualify #(
	parameter int W = 32
) (
	input wire logic [W-1:0] hit_i,
	input wire logic [W-1:0] bind_i,
	input wire logic [W-1:0] match_i,
	output logic [W-1:0] pass_o
);

	// An unbound filter passes on its own hit; a bound one also needs the address match
	assign pass_o = hit_i & (~bind_i | match_i);

endmodule

// ---- ipv4bc_sva.sv ----
module ipv4bc_sva (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic pkt_valid_i,
	input wire logic [10:0] tcp_port_hit_i,
	input wire logic rmcp_hit_i,
	input wire logic mgmt_ipv4_match_i,
	input wire logic host_ipv4_match_i,
	input wire logic reg_rd_i,
	input wire logic reg_rvalid_o,
	input wire logic pass_valid_o,
	input wire logic [31:0] mgmt_pass_o,
	input wire logic [16:0] host_pass_o,
	input wire logic [31:0] mgmt_bind_o,
	input wire logic [16:0] host_bind_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========
	// Bound filters pass only on a match; unbound TCP follows hit; reserved bits clear; valids lag a cycle
	sequence s_mgmt_miss; pkt_valid_i && !mgmt_ipv4_match_i; endsequence
	sequence s_host_miss; pkt_valid_i && !host_ipv4_match_i; endsequence
	property p_mgmt; s_mgmt_miss |=> !(mgmt_pass_o[30:0] & mgmt_bind_o[30:0]); endproperty
	a_mgmt: assert property (p_mgmt) else $error("bound mgmt filter passed");
	property p_rmcp; s_host_miss |=> !(mgmt_pass_o[31] & mgmt_bind_o[31]); endproperty
	a_rmcp: assert property (p_rmcp) else $error("bound rmcp passed");
	property p_rmcp_ok; pkt_valid_i && rmcp_hit_i && host_ipv4_match_i |=> mgmt_pass_o[31]; endproperty
	a_rmcp_ok: assert property (p_rmcp_ok) else $error("rmcp blocked");
	property p_host; s_host_miss |=> !(host_pass_o & host_bind_o); endproperty
	a_host: assert property (p_host) else $error("bound host filter passed");
	property p_free; pkt_valid_i |=> (mgmt_pass_o[10:0] & ~mgmt_bind_o[10:0]) == ($past(tcp_port_hit_i) & ~mgmt_bind_o[10:0]); endproperty
	a_free: assert property (p_free) else $error("unbound tcp filter wrong");
	property p_rsvd; !((mgmt_bind_o | 32'(host_bind_o)) & 32'h0000_2800); endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_pv; 1'b1 |=> pass_valid_o == $past(pkt_valid_i); endproperty
	a_pv: assert property (p_pv) else $error("pass valid timing");
	property p_rv; 1'b1 |=> reg_rvalid_o == $past(reg_rd_i); endproperty
	a_rv: assert property (p_rv) else $error("read valid timing");
endmodule

// ---- ipv4bc_host.sv ----
module ipv4bc_host (
	input wire logic ref_clk_i,
	output logic reg_wr_o = 1'b0,
	output logic reg_rd_o = 1'b0,
	output logic [4:0] reg_phy_addr_o = 5'h00,
	output logic [11:0] reg_page_o = 12'h000,
	output logic [5:0] reg_num_o = 6'h00,
	output logic [15:0] reg_wdata_o = 16'h0000,
	input wire logic [15:0] reg_rdata_i,
	input wire logic reg_rvalid_i
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic wr(input logic [22:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		{reg_phy_addr_o, reg_page_o, reg_num_o} = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_o = 1'b0;
		// Stale data must not look valid
		reg_wdata_o = ~d;
	endtask
	task automatic rd(input logic [22:0] a, output logic [16:0] ans);
		@(negedge ref_clk_i);
		{reg_phy_addr_o, reg_page_o, reg_num_o} = a;
		reg_rd_o = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_o = 1'b0;
		ans = {reg_rvalid_i, reg_rdata_i};
	endtask
endmodule

// ---- ipv4bc_top_tb.sv ----
module ipv4bc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin failures++; $display("FAIL %s exp %h got %h", nm, ex, gt); end end
	localparam logic [16:0] BASE = 17'h01321;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic pkt_valid_i = 1'b0;
	logic reg_wr_i, reg_rd_i, reg_rvalid_o, pass_valid_o, rmcp_hit_i, mgmt_ipv4_match_i, host_ipv4_match_i;
	logic udp_port_filter_zero_hit_i, eap_udp_hit_i, dns_hit_i, range_port_filter_hit_i, icmp_hit_i, arp_hit_i;
	logic [4:0] reg_phy_addr_i;
	logic [11:0] reg_page_i, flex_port_hit_i;
	logic [5:0] reg_num_i;
	logic [15:0] reg_wdata_i, reg_rdata_o;
	logic [10:0] tcp_port_hit_i;
	logic [31:0] mgmt_pass_o, mgmt_bind_o, hit, mat, r;
	logic [16:0] host_pass_o, host_bind_o;
	logic [22:0] a;
	logic [31:0] mdl [2] = '{32'h0, 32'h0};
	logic [31:0] msk [2] = '{32'hFFFF_D7FF, 32'h0001_D7FF};
	int failures = 0;
	int comparisons = 0;
	int cyc = 0;
	ipv4bc_top u_ipv4bc_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_phy_addr_i(reg_phy_addr_i), .reg_page_i(reg_page_i), .reg_num_i(reg_num_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.pkt_valid_i(pkt_valid_i), .tcp_port_hit_i(tcp_port_hit_i),
		.udp_port_filter_zero_hit_i(udp_port_filter_zero_hit_i), .eap_udp_hit_i(eap_udp_hit_i),
		.dns_hit_i(dns_hit_i), .flex_port_hit_i(flex_port_hit_i), .range_port_filter_hit_i(range_port_filter_hit_i),
		.icmp_hit_i(icmp_hit_i), .arp_hit_i(arp_hit_i), .rmcp_hit_i(rmcp_hit_i),
		.mgmt_ipv4_match_i(mgmt_ipv4_match_i), .host_ipv4_match_i(host_ipv4_match_i),
		.pass_valid_o(pass_valid_o), .mgmt_pass_o(mgmt_pass_o), .host_pass_o(host_pass_o),
		.mgmt_bind_o(mgmt_bind_o), .host_bind_o(host_bind_o));
	ipv4bc_host u_ipv4bc_host (.ref_clk_i(ref_clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_phy_addr_o(reg_phy_addr_i), .reg_page_o(reg_page_i), .reg_num_o(reg_num_i),
		.reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
	initial forever #20 ref_clk_i = ~ref_clk_i;
	// ==========
	// Tasks
	task automatic give_verdict();
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [22:0] ad, input logic [15:0] d);
		u_ipv4bc_host.wr(ad, d);
		if (ad[22:2] == {BASE, 4'hA})
			mdl[ad[1]][16 * ad[0] +: 16] = d & msk[ad[1]][16 * ad[0] +: 16];
	endtask
	task automatic rd(input logic [22:0] ad);
		logic [16:0] ans;
		u_ipv4bc_host.rd(ad, ans);
		`CHK("reg_rvalid", 1'b1, ans[16])
		`CHK("reg_rdata", (ad[22:2] == {BASE, 4'hA}) ? mdl[ad[1]][16 * ad[0] +: 16] : 16'h0, ans[15:0])
	endtask
	task automatic pkt();
		@(negedge ref_clk_i);
		{tcp_port_hit_i, udp_port_filter_zero_hit_i, eap_udp_hit_i, dns_hit_i, flex_port_hit_i} = 26'($urandom);
		{range_port_filter_hit_i, icmp_hit_i, arp_hit_i, rmcp_hit_i, mgmt_ipv4_match_i, host_ipv4_match_i} = 6'($urandom);
		pkt_valid_i = 1'b1;
		hit = {rmcp_hit_i, arp_hit_i, icmp_hit_i, range_port_filter_hit_i, flex_port_hit_i, dns_hit_i,
			eap_udp_hit_i, 1'b0, udp_port_filter_zero_hit_i, 1'b0, tcp_port_hit_i};
		mat = {host_ipv4_match_i, {31{mgmt_ipv4_match_i}}};
		@(negedge ref_clk_i);
		pkt_valid_i = 1'b0;
		`CHK("pass_valid", 1'b1, pass_valid_o)
		`CHK("mgmt_pass", hit & (~mdl[0] | mat), mgmt_pass_o)
		`CHK("host_pass", hit[16:0] & (~mdl[1][16:0] | {17{host_ipv4_match_i}}), host_pass_o)
		`CHK("mgmt_bind", mdl[0], mgmt_bind_o)
		`CHK("host_bind", mdl[1][16:0], host_bind_o)
	endtask
	task automatic reset_and_read();
		@(negedge ref_clk_i);
		rst_n_i = 1'b0;
		mdl = '{32'h0, 32'h0};
		repeat (2) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		for (int i = 0; i < 5; i++)
			rd({BASE, 6'(40 + i)});
	endtask
	// ==========
	// Main sequence; a limit on cycles cuts a hang short
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(25663));
		{tcp_port_hit_i, udp_port_filter_zero_hit_i, eap_udp_hit_i, dns_hit_i, flex_port_hit_i} = 26'h0;
		{range_port_filter_hit_i, icmp_hit_i, arp_hit_i, rmcp_hit_i, mgmt_ipv4_match_i, host_ipv4_match_i} = 6'h0;
		reset_and_read();
		repeat (400) begin
			r = $urandom;
			a = {BASE, 4'hA, r[1:0]};
			if (r[4:2] == 3'h0)
				a = r[22:0];
			case (r[6:5])
				2'h0: wr(a, r[7] ? 16'hFFFF : r[31:16]);
				2'h1: rd(a);
				default: pkt();
			endcase
		end
		reset_and_read();
		give_verdict();
	end
endmodule
bind ipv4bc_top ipv4bc_sva u_ipv4bc_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pkt_valid_i(pkt_valid_i),
	.tcp_port_hit_i(tcp_port_hit_i), .rmcp_hit_i(rmcp_hit_i), .mgmt_ipv4_match_i(mgmt_ipv4_match_i),
	.host_ipv4_match_i(host_ipv4_match_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
	.pass_valid_o(pass_valid_o), .mgmt_pass_o(mgmt_pass_o), .host_pass_o(host_pass_o),
	.mgmt_bind_o(mgmt_bind_o), .host_bind_o(host_bind_o));
